/* File: hdl/fsrb_regs.svh */
`ifndef FSRB_REGS_SVH
`define FSRB_REGS_SVH
// Questionable register bit positions
`define FSRB_Q_OV_PROT 0
`define FSRB_Q_OC_SOFT 1
`define FSRB_Q_OV_SOFT 2
`define FSRB_Q_OP_SOFT 3
`define FSRB_Q_OC_PROT 4
`define FSRB_Q_OT_PROT 5
`define FSRB_Q_SENSE_LOSS 6
`define FSRB_Q_REG_LO 7
`define FSRB_Q_SOFT 11
`define FSRB_Q_HARD 12
`define FSRB_Q_INTERLOCK 13
`define FSRB_Q_POWER_LOSS 14
`define FSRB_Q_UIF 15
// Status word 0 bit positions
`define FSRB_S0_STANDBY 0
`define FSRB_S0_LIVE 1
`define FSRB_S0_TRIP_LO 4
`define FSRB_S0_START_FAIL 12
`define FSRB_S0_START_PEND 13
`define FSRB_S0_OC_RATING 16
`define FSRB_S0_OV_RATING 17
`define FSRB_S0_INTERLOCK 20
`define FSRB_S0_LINE_FAULT 26
// Status word 0 bits that are available and read as zero
`define FSRB_S0_UNUSED_MASK 32'h8020000C
// Status word 1 bit positions
`define FSRB_S1_PHASE 0
`define FSRB_S1_FUSE 1
`define FSRB_S1_FAN 2
`define FSRB_S1_TEMP_LO 4
`define FSRB_S1_RATING 16
`define FSRB_S1_FWMIS 17
// Status word 1 bits that carry a condition; all others read as zero
`define FSRB_S1_USED_MASK 32'h000300F7
// Query indices of the status words
`define FSRB_IDX_WORD0 1'h0
`define FSRB_IDX_WORD1 1'h1
// Self-test answers
`define FSRB_TST_PASS 1'h0
`define FSRB_TST_FAIL 1'h1
`endif

/* File: hdl/fsrb_pkg.sv */
package fsrb_pkg;
    // Query kinds accepted on the command port
    typedef enum logic [2:0] {
        FSRB_Q_NONE = 3'h0,
        FSRB_Q_QUES = 3'h1,
        FSRB_Q_REGN = 3'h2,
        FSRB_Q_REGS = 3'h3,
        FSRB_Q_TEST = 3'h4,
        FSRB_Q_WAIT = 3'h5
    } fsrb_cmd_t;
    // Command engine states
    typedef enum logic [2:0] {
        FSRB_IDLE = 3'b001,
        FSRB_TEST = 3'b010,
        FSRB_WAIT = 3'b100
    } fsrb_state_t;
endpackage : fsrb_pkg

/* File: hdl/fsrb_assemble.sv */
`timescale 1ns/100ps
`include "fsrb_regs.svh"
// Combines live condition inputs into the three status images
module fsrb_assemble (
    input wire logic [6:0] hard_soft_in,
    input wire logic [3:0] regulation_in,
    input wire logic [2:0] misc_in,
    input wire logic [31:0] word0_raw,
    input wire logic [31:0] word1_raw,
    output logic [15:0] ques_img,
    output logic [31:0] word0_img,
    output logic [31:0] word1_img
);
    // Soft trips sit at bits 1..3, hard faults at 0 and 4..6
    always_comb begin
        ques_img = 16'h0000;
        ques_img[6:0] = hard_soft_in;
        ques_img[10:7] = regulation_in;
        ques_img[`FSRB_Q_SOFT] = |hard_soft_in[3:1];
        ques_img[`FSRB_Q_HARD] = hard_soft_in[`FSRB_Q_OV_PROT] | (|hard_soft_in[6:4]);
        ques_img[15:13] = misc_in;
    end

    assign word0_img = word0_raw & ~`FSRB_S0_UNUSED_MASK;
    assign word1_img = word1_raw & `FSRB_S1_USED_MASK;
endmodule : fsrb_assemble

/* File: hdl/fsrb_bank.sv */
`timescale 1ns/100ps
`include "fsrb_regs.svh"
module fsrb_bank (
    input wire logic clk,
    input wire logic rst_b,
    // Query port: one-cycle strobe with kind and word index
    input wire logic cmd_valid,
    input wire fsrb_pkg::fsrb_cmd_t cmd_kind,
    input wire logic cmd_index,
    // Command execution state and self-test link
    input wire logic pending_busy,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    // Live condition inputs
    input wire logic overvoltage_protect_fault,
    input wire logic overcurrent_trip_soft,
    input wire logic overvoltage_trip_soft,
    input wire logic overpower_trip_soft,
    input wire logic overcurrent_protect_fault,
    input wire logic overtemperature_fault,
    input wire logic sense_lead_loss,
    input wire logic constant_current_state,
    input wire logic constant_voltage_state,
    input wire logic constant_resistance_state,
    input wire logic constant_power_state,
    input wire logic interlock_open_flag,
    input wire logic input_power_loss,
    input wire logic user_input_fault,
    input wire logic output_standby,
    input wire logic output_live,
    input wire logic current_trip_bit,
    input wire logic voltage_trip_bit,
    input wire logic power_trip_bit,
    input wire logic sense_bounds_bit,
    input wire logic low_voltage_trip_bit,
    input wire logic target_start_failed,
    input wire logic target_start_pending,
    input wire logic [31:0] word0_other,
    input wire logic missing_phase_bit,
    input wire logic input_fuse_bit,
    input wire logic fan_locked_bit,
    input wire logic [3:0] module_temp_bits,
    input wire logic bad_rating_bit,
    input wire logic firmware_mismatch_bit,
    // Answers
    output logic cmd_ready,
    output logic selftest_start,
    output logic resp_valid,
    output logic resp_pair,
    output logic [31:0] resp_data0,
    output logic [31:0] resp_data1,
    output logic [15:0] questionable_condition,
    output logic [31:0] status_word_zero,
    output logic [31:0] status_word_one
);
    fsrb_pkg::fsrb_state_t state_ff, nxt_state;
    logic [15:0] ques_img;
    logic [31:0] word0_img, word1_img, word0_raw, word1_raw;
    logic accept;

    // Fold documented bits into word 0; other live bits pass through
    always_comb begin
        word0_raw = word0_other;
        word0_raw[`FSRB_S0_STANDBY] = output_standby;
        word0_raw[`FSRB_S0_LIVE] = output_live;
        word0_raw[8:4] = {low_voltage_trip_bit, sense_bounds_bit, power_trip_bit,
                          voltage_trip_bit, current_trip_bit};
        word0_raw[`FSRB_S0_START_FAIL] = target_start_failed;
        word0_raw[`FSRB_S0_START_PEND] = target_start_pending;
        word0_raw[`FSRB_S0_OC_RATING] = overcurrent_protect_fault;
        word0_raw[`FSRB_S0_OV_RATING] = overvoltage_protect_fault;
        // interlock and input faults mirror questionable bits
        word0_raw[`FSRB_S0_INTERLOCK] = interlock_open_flag;
        word0_raw[`FSRB_S0_LINE_FAULT] = user_input_fault;
    end

    // Word 1 layout
    always_comb begin
        word1_raw = 32'h00000000;
        word1_raw[2:0] = {fan_locked_bit, input_fuse_bit, missing_phase_bit};
        word1_raw[7:4] = module_temp_bits;
        word1_raw[`FSRB_S1_RATING] = bad_rating_bit;
        word1_raw[`FSRB_S1_FWMIS] = firmware_mismatch_bit;
    end

    // hard and soft bits placed at fixed positions
    fsrb_assemble u_asm (
        .hard_soft_in({sense_lead_loss, overtemperature_fault, overcurrent_protect_fault,
                       overpower_trip_soft, overvoltage_trip_soft, overcurrent_trip_soft,
                       overvoltage_protect_fault}),
        .regulation_in({constant_power_state, constant_resistance_state,
                        constant_voltage_state, constant_current_state}),
        .misc_in({user_input_fault, input_power_loss, interlock_open_flag}),
        .word0_raw(word0_raw),
        .word1_raw(word1_raw),
        .ques_img(ques_img),
        .word0_img(word0_img),
        .word1_img(word1_img)
    );

    // live images registered every cycle, never cleared by a read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            questionable_condition <= 16'h0000;
            status_word_zero <= 32'h00000000;
            status_word_one <= 32'h00000000;
        end else begin
            questionable_condition <= ques_img;
            status_word_zero <= word0_img;
            status_word_one <= word1_img;
        end
    end

    assign accept = cmd_valid && cmd_ready;

    // Command engine: self-test runs and waits stall the port
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fsrb_pkg::FSRB_IDLE: begin
                if (accept && cmd_kind == fsrb_pkg::FSRB_Q_TEST) begin
                    nxt_state = fsrb_pkg::FSRB_TEST;
                end else if (accept && cmd_kind == fsrb_pkg::FSRB_Q_WAIT) begin
                    nxt_state = fsrb_pkg::FSRB_WAIT;
                end
            end
            fsrb_pkg::FSRB_TEST: begin
                if (selftest_done) begin
                    nxt_state = fsrb_pkg::FSRB_IDLE;
                end
            end
            fsrb_pkg::FSRB_WAIT: begin
                if (!pending_busy) begin
                    nxt_state = fsrb_pkg::FSRB_IDLE;
                end
            end
            default: nxt_state = fsrb_pkg::FSRB_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= fsrb_pkg::FSRB_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Ready only when idle; a wait stalls everything behind it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= (nxt_state == fsrb_pkg::FSRB_IDLE) && !accept;
        end
    end

    // One-cycle start pulse toward the self-test checks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            selftest_start <= 1'b0;
        end else begin
            selftest_start <= accept && cmd_kind == fsrb_pkg::FSRB_Q_TEST;
        end
    end

    // Response path; reads have no side effect on any image
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            resp_valid <= 1'b0;
            resp_pair <= 1'b0;
            resp_data0 <= 32'h00000000;
            resp_data1 <= 32'h00000000;
        end else begin
            resp_valid <= 1'b0;
            resp_pair <= 1'b0;
            if (state_ff == fsrb_pkg::FSRB_TEST && selftest_done) begin
                // pass gives 0, fail gives 1
                resp_valid <= 1'b1;
                resp_data0 <= {31'h00000000, selftest_fail ? `FSRB_TST_FAIL : `FSRB_TST_PASS};
                resp_data1 <= 32'h00000000;
            end else if (accept) begin
                case (cmd_kind)
                    fsrb_pkg::FSRB_Q_QUES: begin
                        resp_valid <= 1'b1;
                        resp_data0 <= {16'h0000, ques_img};
                        resp_data1 <= 32'h00000000;
                    end
                    fsrb_pkg::FSRB_Q_REGN: begin
                        resp_valid <= 1'b1;
                        resp_data0 <= (cmd_index == `FSRB_IDX_WORD1) ? word1_img : word0_img;
                        resp_data1 <= 32'h00000000;
                    end
                    fsrb_pkg::FSRB_Q_REGS: begin
                        resp_valid <= 1'b1;
                        resp_pair <= 1'b1;
                        resp_data0 <= word0_img;
                        resp_data1 <= word1_img;
                    end
                    default: begin
                        resp_data0 <= resp_data0;
                    end
                endcase
            end
        end
    end
endmodule : fsrb_bank

/* File: verification/fsrb_check_model.sv */
`timescale 1ns/100ps
// Stand-in for the internal checks behind the self-test query
module fsrb_check_model #(
    parameter int DELAY = 5
) (
    input wire logic clk,
    input wire logic selftest_start,
    input wire logic fail_mode,
    output logic selftest_done = 1'b0,
    output logic selftest_fail = 1'b0
);
    int cnt_ff = 0;
    // verdict only valid with done
    // Outside done the verdict line shows junk so a sloppy sample shows up
    always @(posedge clk) begin
        selftest_done <= (cnt_ff == 1);
        selftest_fail <= (cnt_ff == 1) ? fail_mode : ~fail_mode;
        cnt_ff <= selftest_start ? DELAY : ((cnt_ff > 0) ? cnt_ff - 1 : 0);
    end
endmodule : fsrb_check_model

/* File: verification/fsrb_bank_asserts.sv */
`timescale 1ns/100ps
// Port-level checks on the status bank
module fsrb_bank_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire fsrb_pkg::fsrb_cmd_t cmd_kind,
    input wire logic cmd_index,
    input wire logic pending_busy,
    input wire logic selftest_done,
    input wire logic selftest_fail,
    input wire logic cmd_ready,
    input wire logic resp_valid,
    input wire logic resp_pair,
    input wire logic [31:0] resp_data0,
    input wire logic [31:0] resp_data1,
    input wire logic [15:0] questionable_condition,
    input wire logic [31:0] status_word_zero,
    input wire logic [31:0] status_word_one
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic tk;
    // A query is taken only when both sides agree
    assign tk = cmd_valid && cmd_ready;
    AST_QUES: assert property (tk && cmd_kind == fsrb_pkg::FSRB_Q_QUES |=>
        resp_valid && !resp_pair && resp_data0[15:0] == questionable_condition)
        else $error("questionable answer wrong");
    AST_REGS: assert property (tk && cmd_kind == fsrb_pkg::FSRB_Q_REGS |=>
        resp_valid && resp_pair && resp_data0 == status_word_zero
        && resp_data1 == status_word_one) else $error("paired answer wrong");
    AST_REGN: assert property (tk && cmd_kind == fsrb_pkg::FSRB_Q_REGN |=>
        resp_valid && !resp_pair
        && resp_data0 == ($past(cmd_index) ? status_word_one : status_word_zero))
        else $error("indexed answer wrong");
    AST_SOFT: assert property (questionable_condition[11] ==
        |questionable_condition[3:1]) else $error("soft summary wrong");
    AST_HARD: assert property (questionable_condition[12] ==
        |{questionable_condition[6:4], questionable_condition[0]})
        else $error("hard summary wrong");
    AST_UNUSED: assert property ((status_word_zero & 32'h8020000C) == 32'h0
        && (status_word_one & 32'hFFFCFF08) == 32'h0) else $error("available bit set");
    AST_TEST: assert property (!cmd_ready && selftest_done |=>
        resp_valid && resp_data0 == {31'h0, $past(selftest_fail)})
        else $error("self-test answer wrong");
    AST_WAIT: assert property (tk && cmd_kind == fsrb_pkg::FSRB_Q_WAIT
        ##1 pending_busy [*2] |=> !cmd_ready) else $error("wait released early");
endmodule : fsrb_bank_asserts
bind fsrb_bank fsrb_bank_asserts i_chk (.clk, .rst_b, .cmd_valid, .cmd_kind, .cmd_index,
    .pending_busy, .selftest_done, .selftest_fail, .cmd_ready, .resp_valid, .resp_pair,
    .resp_data0, .resp_data1, .questionable_condition, .status_word_zero, .status_word_one);

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk, rst_b, cmd_valid, cmd_index, pending_busy, fail_mode;
    fsrb_pkg::fsrb_cmd_t cmd_kind;
    logic [31:0] c, w, resp_data0, resp_data1, status_word_zero, status_word_one;
    logic cmd_ready, selftest_start, selftest_done, selftest_fail, resp_valid, resp_pair;
    logic [15:0] questionable_condition;
    int n_errors = 0, checked = 0, cyc = 0;
    fsrb_bank i_dut (.clk, .rst_b, .cmd_valid, .cmd_kind, .cmd_index, .pending_busy,
        .selftest_done, .selftest_fail, .overvoltage_protect_fault(c[0]),
        .overcurrent_trip_soft(c[1]), .overvoltage_trip_soft(c[2]),
        .overpower_trip_soft(c[3]), .overcurrent_protect_fault(c[4]),
        .overtemperature_fault(c[5]), .sense_lead_loss(c[6]), .constant_current_state(c[7]),
        .constant_voltage_state(c[8]), .constant_resistance_state(c[9]),
        .constant_power_state(c[10]), .interlock_open_flag(c[11]), .input_power_loss(c[12]),
        .user_input_fault(c[13]), .output_standby(c[14]), .output_live(c[15]),
        .current_trip_bit(c[16]), .voltage_trip_bit(c[17]), .power_trip_bit(c[18]),
        .sense_bounds_bit(c[19]), .low_voltage_trip_bit(c[20]), .target_start_failed(c[21]),
        .target_start_pending(c[22]), .word0_other(w), .missing_phase_bit(c[23]),
        .input_fuse_bit(c[24]), .fan_locked_bit(c[25]), .module_temp_bits(c[29:26]),
        .bad_rating_bit(c[30]), .firmware_mismatch_bit(c[31]), .cmd_ready, .selftest_start,
        .resp_valid, .resp_pair, .resp_data0, .resp_data1, .questionable_condition,
        .status_word_zero, .status_word_one);
    fsrb_check_model i_chk_model (.clk, .selftest_start, .fail_mode, .selftest_done,
        .selftest_fail);
    // Clock at 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Expected images built bit by bit from the condition vector
    function automatic logic [15:0] eq();
        return {c[13:11], c[0] | c[4] | c[5] | c[6], |c[3:1], c[10:0]};
    endfunction : eq
    function automatic logic [31:0] ew0();
        logic [31:0] r;
        r = w & ~32'h8020000C;
        r[1:0] = c[15:14];
        r[8:4] = c[20:16];
        r[13:12] = c[22:21];
        r[17:16] = {c[0], c[4]};
        r[20] = c[11];
        r[26] = c[13];
        return r;
    endfunction : ew0
    function automatic logic [31:0] ew1();
        return {14'h0, c[31:30], 8'h0, c[29:26], 1'h0, c[25:23]};
    endfunction : ew1
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, a, e);
        end
    endtask : cmp
    // Waits for ready, strobes one query, returns at the answer cycle
    task automatic query(input fsrb_pkg::fsrb_cmd_t k, input logic i);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_index <= i;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
    endtask : query
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = fsrb_pkg::FSRB_Q_NONE;
        cmd_index = 1'b0;
        pending_busy = 1'b0;
        fail_mode = 1'b0;
        c = 32'h0;
        w = 32'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        // Walk one condition at a time, word-0 fill toggling, then none set, then all set
        for (int i = 0; i < 34; i++) begin
            @(posedge clk);
            c <= (i == 33) ? 32'hFFFFFFFF : 32'h1 << i;
            w <= i[0] ? 32'hFFFFFFFF : 32'h0;
            query(fsrb_pkg::FSRB_Q_QUES, 1'b0);
            cmp({resp_valid, resp_pair}, 2'h2);
            cmp(resp_data0[15:0], eq());
            cmp(questionable_condition, eq());
            query(fsrb_pkg::FSRB_Q_REGS, 1'b0);
            cmp({resp_valid, resp_pair}, 2'h3);
            cmp(resp_data0, ew0());
            cmp(resp_data1, ew1());
            query(fsrb_pkg::FSRB_Q_REGN, i[0]);
            cmp({resp_valid, resp_pair}, 2'h2);
            cmp(resp_data0, i[0] ? ew1() : ew0());
            cmp(status_word_zero, ew0());
        end
        // Self-test passing then failing
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fail_mode <= f[0];
            query(fsrb_pkg::FSRB_Q_TEST, 1'b0);
            for (int n = 0; n < 30 && resp_valid !== 1'b1; n++) @(negedge clk);
            cmp(resp_data0, f);
        end
        // Wait holds off commands while earlier ones run
        @(posedge clk);
        pending_busy <= 1'b1;
        query(fsrb_pkg::FSRB_Q_WAIT, 1'b0);
        repeat (5) @(negedge clk);
        cmp(cmd_ready, 1'b0);
        @(posedge clk);
        pending_busy <= 1'b0;
        query(fsrb_pkg::FSRB_Q_QUES, 1'b0);
        cmp(resp_valid, 1'b1);
        final_report();
    end
endmodule : testbench
